// ### logic/fdp_mode_pins.sv
// Floppy system-mode gating, shared pins and AXI4-Lite register slave
//
// Functional notes
// R1 - Reset samples identity and encoding straps into mode
// R2 - AT mode: DMA enable honoured, count high, A/B off
// R3 - Third mode: DMA enable honoured, count high, A/B on
// R4 - Second mode: request/interrupt always on, count low
// R5 - Density select polarity follows identity strap
// R6 - Idle-select bit picks idle or motor
// R7 - Idle indicator high when idle or powered down
// R8 - Drive pulses index marking each track start
// R9 - Parallel-port mode adds second index input; the logic drops it while the port flag control bit is set
// R10 - Ready-select bit picks open-drain ready or encoding
// R11 - Sampled mode held until next reset
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "fdp_cfg.svh"
module fdp_mode_pins (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Straps and controller core
  input wire logic identity_strap,
  input wire logic encoding_pin_in,
  input wire logic fdc_idle,
  input wire logic fdc_power_down,
  input wire logic core_dma_request,
  input wire logic core_interrupt,
  input wire logic high_rate,
  input wire logic encoding_current,
  input wire logic ready_stretch,
  input wire logic drive1_motor_select_n,
  input wire logic [7:0] status_a_in,
  input wire logic [7:0] status_b_in,
  // Drive side
  input wire logic terminal_count,
  input wire logic index_n,
  input wire logic ppm_index_n,
  output logic floppy_dma_request,
  output logic floppy_interrupt,
  output logic terminal_count_active,
  output logic density_select_out,
  output logic idle_indicator,
  output logic pin43_out,
  output logic pin53_out,
  output logic pin53_oe_n,
  output logic status_ab_enable,
  output logic track_start
);
  import fdp_pkg::*;

  fdp_state_t st_ff;
  fdp_state_t nxt_st;
  fdp_mode_t mode;
  logic illegal;
  logic ident_high;

  // ****************************************************************
  // Strap latch
  // ****************************************************************
  fdp_strap_latch u_strap (
    .aclk(aclk),
    .aresetn(aresetn),
    .identity_strap(identity_strap),
    .encoding_pin_in(encoding_pin_in),
    .mode(mode),
    .illegal(illegal),
    .ident_high(ident_high)
  );

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // Mode gating, pin muxing, index edge and bus slave in one pass
  always_comb begin
    logic dma_gate;
    logic tc_high;
    logic ab_on;
    logic idx_act;
    logic [31:0] rd;
    logic [1:0] rr;
    dma_gate = 1'b0;
    tc_high = 1'b1;
    ab_on = 1'b0;
    idx_act = 1'b0;
    rd = 32'h0000_0000;
    rr = `FDP_RESP_OKAY;
    nxt_st = st_ff;

    // Mode decides gating, count polarity and A/B visibility
    unique case (mode)
      FDP_MODE_AT: begin
        dma_gate = st_ff.ctrl[`FDP_CTRL_DMA_EN_BIT]; // R2
        tc_high = 1'b1; // R2
        ab_on = 1'b0; // R2
      end
      FDP_MODE_SYS3: begin
        dma_gate = st_ff.ctrl[`FDP_CTRL_DMA_EN_BIT]; // R3
        tc_high = 1'b1; // R3
        ab_on = 1'b1; // R3
      end
      FDP_MODE_SYS2: begin
        dma_gate = 1'b1; // R4
        tc_high = 1'b0; // R4
        ab_on = 1'b1; // R4
      end
    endcase
    nxt_st.dreq = core_dma_request & dma_gate;
    nxt_st.irq = core_interrupt & dma_gate;
    nxt_st.tc_act = tc_high ? terminal_count : ~terminal_count;
    nxt_st.stat_ab_en = ab_on;

    // Polarity fixed by strap so high rates map to the right drive level
    nxt_st.dens = ident_high ? high_rate : ~high_rate; // R5

    // Idle indicator and the shared motor pin
    nxt_st.idle_ind = fdc_idle | fdc_power_down; // R7
    nxt_st.pin43 = st_ff.ctrl[`FDP_CTRL_IDLE_SEL_BIT] ? (fdc_idle | fdc_power_down)
                                                     : drive1_motor_select_n; // R6

    // Ready pin only pulls low; encoding output drives both levels
    if (st_ff.ctrl[`FDP_CTRL_READY_SEL_BIT]) begin
      nxt_st.pin53_out = encoding_current; // R10
      nxt_st.pin53_oe_n = 1'b0; // R10
    end else begin
      nxt_st.pin53_out = 1'b0; // R10
      nxt_st.pin53_oe_n = ~ready_stretch; // R10
    end

    // Track start is the leading edge of either index source
    idx_act = ~index_n; // R8
    if (st_ff.ctrl[`FDP_CTRL_PPM_BIT] && !st_ff.ctrl[`FDP_CTRL_PORT_FLAG_BIT]) begin
      idx_act = idx_act | ~ppm_index_n; // R9
    end
    nxt_st.idx_prev = idx_act;
    nxt_st.track_start = idx_act & ~st_ff.idx_prev; // R8
    if (idx_act && !st_ff.idx_prev) begin
      nxt_st.idx_count = st_ff.idx_count + 8'h01;
    end

    // Write address and data may arrive in either order
    if (s_axi_awvalid && st_ff.aw_rdy) begin
      nxt_st.aw_rdy = 1'b0;
      nxt_st.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_ff.w_rdy) begin
      nxt_st.w_rdy = 1'b0;
      nxt_st.wdata = s_axi_wdata[7:0];
      nxt_st.wstrb0 = s_axi_wstrb[0];
    end
    // Both halves held: commit and answer next cycle
    if (!st_ff.aw_rdy && !st_ff.w_rdy && !st_ff.bvalid) begin
      nxt_st.bvalid = 1'b1;
      if (st_ff.waddr == `FDP_ADDR_CTRL) begin
        nxt_st.bresp = `FDP_RESP_OKAY;
        if (st_ff.wstrb0) begin
          nxt_st.ctrl = st_ff.wdata & `FDP_CTRL_MASK;
        end
      end else if (st_ff.waddr == `FDP_ADDR_STATUS || st_ff.waddr == `FDP_ADDR_STAT_A ||
                   st_ff.waddr == `FDP_ADDR_STAT_B) begin
        nxt_st.bresp = `FDP_RESP_OKAY; // Read-only, write ignored
      end else begin
        nxt_st.bresp = `FDP_RESP_SLVERR;
      end
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
      nxt_st.aw_rdy = 1'b1;
      nxt_st.w_rdy = 1'b1;
    end

    // Read decode; A/B undriven in AT mode answers as an error with zero
    unique case (s_axi_araddr)
      `FDP_ADDR_CTRL: begin
        rd[7:0] = st_ff.ctrl;
      end
      `FDP_ADDR_STATUS: begin
        rd[`FDP_STAT_MODE_LSB +: 3] = mode;
        rd[`FDP_STAT_ILLEGAL_BIT] = illegal;
        rd[`FDP_STAT_IDENT_BIT] = ident_high;
        rd[`FDP_STAT_IDLE_BIT] = st_ff.idle_ind;
        rd[`FDP_STAT_TC_BIT] = st_ff.tc_act;
        rd[`FDP_STAT_INDEX_BIT] = st_ff.idx_prev;
        rd[`FDP_STAT_COUNT_LSB +: 8] = st_ff.idx_count;
      end
      `FDP_ADDR_STAT_A: begin
        if (ab_on) begin
          rd[7:0] = status_a_in; // R3
        end else begin
          rr = `FDP_RESP_SLVERR; // R2
        end
      end
      `FDP_ADDR_STAT_B: begin
        if (ab_on) begin
          rd[7:0] = status_b_in; // R3
        end else begin
          rr = `FDP_RESP_SLVERR; // R2
        end
      end
      default: begin
        rr = `FDP_RESP_SLVERR;
      end
    endcase
    if (s_axi_arvalid && st_ff.ar_rdy) begin
      nxt_st.ar_rdy = 1'b0;
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = rd;
      nxt_st.rresp = rr;
    end
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
      nxt_st.ar_rdy = 1'b1;
    end

    // Reset: everything inactive, strap pin released for sampling
    if (!aresetn) begin
      nxt_st = '0;
      nxt_st.ctrl = `FDP_CTRL_RST;
      nxt_st.aw_rdy = 1'b1;
      nxt_st.w_rdy = 1'b1;
      nxt_st.ar_rdy = 1'b1;
      nxt_st.pin43 = 1'b1;
      nxt_st.pin53_oe_n = 1'b1;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge aclk) begin
    st_ff <= nxt_st;
  end

  // Outputs straight from the state flops
  assign s_axi_awready = st_ff.aw_rdy;
  assign s_axi_wready = st_ff.w_rdy;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = st_ff.ar_rdy;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign floppy_dma_request = st_ff.dreq;
  assign floppy_interrupt = st_ff.irq;
  assign terminal_count_active = st_ff.tc_act;
  assign density_select_out = st_ff.dens;
  assign idle_indicator = st_ff.idle_ind;
  assign pin43_out = st_ff.pin43;
  assign pin53_out = st_ff.pin53_out;
  assign pin53_oe_n = st_ff.pin53_oe_n;
  assign status_ab_enable = st_ff.stat_ab_en;
  assign track_start = st_ff.track_start;
endmodule : fdp_mode_pins
`default_nettype wire

// ### logic/fdp_cfg.svh
// Offsets, field positions, reset values and codes of the floppy system-mode block
`ifndef FDP_CFG_SVH
`define FDP_CFG_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define FDP_ADDR_CTRL 8'h00
`define FDP_ADDR_STATUS 8'h04
`define FDP_ADDR_STAT_A 8'h08
`define FDP_ADDR_STAT_B 8'h0C

// ****************************************************************
// Control register fields
// ****************************************************************
`define FDP_CTRL_PPM_BIT 0
`define FDP_CTRL_PORT_FLAG_BIT 1
`define FDP_CTRL_DMA_EN_BIT 3
`define FDP_CTRL_IDLE_SEL_BIT 4
`define FDP_CTRL_READY_SEL_BIT 7
`define FDP_CTRL_RST 8'h00
`define FDP_CTRL_MASK 8'h9B

// ****************************************************************
// Status register fields
// ****************************************************************
`define FDP_STAT_MODE_LSB 0
`define FDP_STAT_ILLEGAL_BIT 3
`define FDP_STAT_IDENT_BIT 4
`define FDP_STAT_IDLE_BIT 5
`define FDP_STAT_TC_BIT 6
`define FDP_STAT_INDEX_BIT 7
`define FDP_STAT_COUNT_LSB 8

// ****************************************************************
// Bus answers
// ****************************************************************
`define FDP_RESP_OKAY 2'h0
`define FDP_RESP_SLVERR 2'h2

`endif

// ### logic/fdp_pkg.sv
// Types shared by the floppy system-mode block
`default_nettype none
package fdp_pkg;

  // System modes, one-hot
  typedef enum logic [2:0] {
    FDP_MODE_AT = 3'b001,
    FDP_MODE_SYS2 = 3'b010,
    FDP_MODE_SYS3 = 3'b100
  } fdp_mode_t;

  // Strap latch state
  typedef struct packed {
    fdp_mode_t mode;
    logic illegal;
    logic ident_high;
  } fdp_strap_t;

  // Main block state
  typedef struct packed {
    logic [7:0] ctrl;
    logic aw_rdy;
    logic w_rdy;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic dreq;
    logic irq;
    logic tc_act;
    logic dens;
    logic idle_ind;
    logic pin43;
    logic pin53_out;
    logic pin53_oe_n;
    logic stat_ab_en;
    logic idx_prev;
    logic track_start;
    logic [7:0] idx_count;
  } fdp_state_t;

endpackage : fdp_pkg
`default_nettype wire

// ### logic/fdp_strap_latch.sv
// Reset-time strap sampler holding the system mode
`timescale 1ns/1ps
`default_nettype none
module fdp_strap_latch (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic identity_strap,
  input wire logic encoding_pin_in,
  output fdp_pkg::fdp_mode_t mode,
  output logic illegal,
  output logic ident_high
);
  import fdp_pkg::*;

  fdp_strap_t st_ff;
  fdp_strap_t nxt_st;

  // ****************************************************************
  // Sampling
  // ****************************************************************
  // Follow the straps while reset is held, freeze at release
  always_comb begin
    nxt_st = st_ff;
    if (!aresetn) begin
      nxt_st.ident_high = identity_strap; // R1
      nxt_st.illegal = identity_strap & ~encoding_pin_in; // R1
      if (identity_strap) begin
        nxt_st.mode = FDP_MODE_AT; // R1
      end else if (encoding_pin_in) begin
        nxt_st.mode = FDP_MODE_SYS2; // R1
      end else begin
        nxt_st.mode = FDP_MODE_SYS3; // R1
      end
    end
  end

  // Straps are ignored once running
  always_ff @(posedge aclk) begin
    st_ff <= nxt_st; // R11
  end

  assign mode = st_ff.mode;
  assign illegal = st_ff.illegal;
  assign ident_high = st_ff.ident_high;
endmodule : fdp_strap_latch
`default_nettype wire

// ### test/fdp_mode_pins_monitor.sv
// Checker of the floppy system-mode pin block
`timescale 1ns/1ps
`default_nettype none
module fdp_mode_pins_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic identity_strap,
  input wire logic encoding_pin_in,
  input wire logic fdc_idle,
  input wire logic fdc_power_down,
  input wire logic core_dma_request,
  input wire logic core_interrupt,
  input wire logic high_rate,
  input wire logic encoding_current,
  input wire logic ready_stretch,
  input wire logic terminal_count,
  input wire logic floppy_dma_request,
  input wire logic floppy_interrupt,
  input wire logic terminal_count_active,
  input wire logic density_select_out,
  input wire logic idle_indicator,
  input wire logic pin53_out,
  input wire logic pin53_oe_n,
  input wire logic status_ab_enable
);
  logic id_ff, en_ff, up_ff, sys2;
  // Straps as seen at the last reset edge; up_ff skips the first edge after release
  always_ff @(posedge aclk) begin
    up_ff <= aresetn;
    if (!aresetn) begin
      id_ff <= identity_strap;
      en_ff <= encoding_pin_in;
    end
  end
  assign sys2 = !id_ff && en_ff;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_IDLE: assert property (up_ff |-> idle_indicator == $past(fdc_idle | fdc_power_down)) else $error("idle");
  AST_DENS: assert property (up_ff |-> density_select_out == (id_ff ~^ $past(high_rate))) else $error("dens");
  AST_TC: assert property (up_ff |-> terminal_count_active == ($past(terminal_count) ^ sys2)) else $error("tc");
  AST_AB: assert property (up_ff |-> status_ab_enable == !id_ff) else $error("ab");
  AST_GATE: assert property (up_ff && sys2 |-> floppy_dma_request == $past(core_dma_request)
    && floppy_interrupt == $past(core_interrupt)) else $error("gate");
  AST_NOREQ: assert property (up_ff && !$past(core_interrupt) |-> !floppy_interrupt) else $error("irq");
  AST_OD: assert property (up_ff && pin53_oe_n |-> !$past(ready_stretch) && !pin53_out) else $error("od");
  AST_P53: assert property (up_ff && !pin53_oe_n |-> pin53_out == $past(encoding_current)
    || !pin53_out && $past(ready_stretch)) else $error("p53");
endmodule : fdp_mode_pins_monitor
bind fdp_mode_pins fdp_mode_pins_monitor u_fdp_mode_pins_monitor (.*);
`default_nettype wire

// ### test/fdp_drive_model.sv
// Floppy drive model pulsing the index line
`timescale 1ns/1ps
`default_nettype none
module fdp_drive_model #(parameter int PERIOD = 25) (
  input wire logic aclk,
  input wire logic spin,
  output logic index_n,
  output int n_idx
);
  int cnt = 0;
  initial index_n = 1'b1;
  initial n_idx = 0;
  // Two-cycle low index at each track start; line pulled high when stopped
  always @(posedge aclk) begin
    if (spin) cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
    index_n <= !(spin && cnt < 2);
    if (spin && cnt == 0) n_idx <= n_idx + 1;
  end
endmodule : fdp_drive_model
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench of the floppy system-mode pin block
`timescale 1ns/1ps
`default_nettype none
`include "fdp_cfg.svh"
module tb_top;
  import fdp_pkg::*;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, spin = 0, parallel_port_floppy_mode = 0;
  logic ids = 1, ens = 1, idst = 1, enst = 1;
  logic [7:0] awa = 0, ara = 0, sta = 0, outs;
  logic [31:0] wd = 0, rdat;
  logic [8:0] pins = 0;
  logic awr, wr_r, bv, arr, rv, idx, tsp;
  logic [3:0] ws = 4'hF;
  int n_ts = 0;
  logic [1:0] br, rr;
  int n_fail = 0, comparisons = 0, seed = 32'h13434db5, n_idx, base, tot;
  fdp_mode_pins u_fdp_mode_pins (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .identity_strap(idst), .encoding_pin_in(enst), .fdc_idle(pins[8]), .fdc_power_down(pins[7]),
    .core_dma_request(pins[6]), .core_interrupt(pins[5]), .high_rate(pins[4]), .encoding_current(pins[3]),
    .ready_stretch(pins[2]), .drive1_motor_select_n(pins[1]), .status_a_in(sta), .status_b_in(~sta),
    .terminal_count(pins[0]), .index_n(parallel_port_floppy_mode | idx), .ppm_index_n(!parallel_port_floppy_mode | idx), .floppy_dma_request(outs[7]),
    .floppy_interrupt(outs[6]), .terminal_count_active(outs[5]), .density_select_out(outs[4]),
    .idle_indicator(outs[3]), .pin43_out(outs[2]), .pin53_out(outs[1]), .pin53_oe_n(outs[0]),
    .status_ab_enable(), .track_start(tsp));
  fdp_drive_model u_fdp_drive_model (.aclk(aclk), .spin(spin), .index_n(idx), .n_idx(n_idx));
  // Track-start pulses seen, counted once per edge so a stuck pulse over-counts
  always @(posedge aclk) begin
    if (tsp === 1'b1) n_ts <= n_ts + 1;
  end
  initial forever #4 aclk = !aclk;
  // Hang guard well beyond the expected run
  initial begin
    repeat (8000) @(posedge aclk);
    n_fail++;
    final_report;
  end
  // ****************************************************************
  // Tasks and expectations
  // ****************************************************************
  task automatic final_report;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // Straps change right after release; the sampled mode must stay
  task automatic do_reset;
    @(posedge aclk);
    idst <= ids;
    enst <= ens;
    aresetn <= 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    idst <= !ids;
    enst <= !ens;
  endtask : do_reset
  task automatic wr(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] r);
    logic aw, w;
    aw = 1;
    w = 1;
    @(posedge aclk);
    awa <= a;
    wd <= dv;
    awv <= 1;
    wv <= 1;
    bry <= 1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && awr) begin
        aw = 0;
        awv <= 0;
      end
      if (w && wr_r) begin
        w = 0;
        wv <= 0;
      end
    end
    do @(posedge aclk); while (!bv);
    r = br;
    bry <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    ara <= a;
    arv <= 1;
    rry <= 1;
    do @(posedge aclk); while (!arr);
    arv <= 0;
    do @(posedge aclk); while (!rv);
    d = rdat;
    r = rr;
    rry <= 0;
  endtask : rd
  // Pin outputs one cycle after the inputs, per mode and control bits
  function automatic logic [7:0] exp_pins(logic [7:0] c, logic [8:0] v);
    logic s2, g, il;
    s2 = !ids & ens;
    g = s2 | c[3];
    il = v[8] | v[7];
    return {v[6] & g, v[5] & g, v[0] ^ s2, ids ~^ v[4], il, c[4] ? il : v[1], c[7] & v[3], c[7] ? 1'b0 : !v[2]};
  endfunction : exp_pins
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] c;
    for (int m = 0; m < 4; m++) begin
      ids = m[1];
      ens = m[0];
      do_reset;
      rd(`FDP_ADDR_STATUS, d, r);
      chk("mode", {ids, ids & !ens, !ids & !ens, !ids & ens, ids}, d[4:0]);
      sta <= 8'($random(seed));
      rd(`FDP_ADDR_STAT_A, d, r);
      chk("stat_a", ids ? {`FDP_RESP_SLVERR, 8'h00} : {`FDP_RESP_OKAY, sta}, {r, d[7:0]});
      rd(`FDP_ADDR_STAT_B, d, r);
      chk("stat_b", ids ? {`FDP_RESP_SLVERR, 8'h00} : {`FDP_RESP_OKAY, ~sta}, {r, d[7:0]});
      for (int k = 0; k < 3; k++) begin
        c = (k == 0) ? 8'h00 : 8'($random(seed)) | (k == 1 ? 8'h98 : 8'h00);
        wr(`FDP_ADDR_CTRL, {24'h0, c}, r);
        c = c & `FDP_CTRL_MASK;
        rd(`FDP_ADDR_CTRL, d, r);
        chk("ctrl", c, d);
        repeat (8) begin
          @(posedge aclk);
          pins <= 9'($random(seed));
          @(posedge aclk);
          #1 chk("pins", exp_pins(c, pins), outs);
        end
      end
    end
    // Byte lane 0 off: control must keep its last value
    ws <= 4'h0;
    wr(`FDP_ADDR_CTRL, 32'hFF, r);
    ws <= 4'hF;
    rd(`FDP_ADDR_CTRL, d, r);
    chk("strb", c, d);
    wr(`FDP_ADDR_STATUS, 32'hFF, r);
    chk("ro_resp", `FDP_RESP_OKAY, r);
    rd(8'h10, d, r);
    chk("unmapped", {`FDP_RESP_SLVERR, 32'h0}, {r, d});
    // Normal index, port index enabled, port index blocked by the flag
    tot = 0;
    for (int k = 0; k < 3; k++) begin
      wr(`FDP_ADDR_CTRL, k ? {30'h0, k[1], 1'b1} : 32'h0, r);
      parallel_port_floppy_mode <= k != 0;
      base = n_idx;
      spin <= 1;
      repeat (200) @(posedge aclk);
      spin <= 0;
      repeat (4) @(posedge aclk);
      tot += (k == 2) ? 0 : n_idx - base;
      rd(`FDP_ADDR_STATUS, d, r);
      chk("tracks", tot[7:0], d[15:8]);
      chk("starts", tot, n_ts);
    end
    final_report;
  end
endmodule : tb_top
`default_nettype wire
